/* core/ftm_pkg.sv */
// Package: register map, field layout, reset values and types of the fan tachometer monitor
package ftm_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] FTM_OFF_CTRL = 8'h00;
    localparam logic [7:0] FTM_OFF_STATUS = 8'h04;
    localparam logic [7:0] FTM_OFF_INT_EN = 8'h08;
    localparam logic [7:0] FTM_OFF_INT_CLR = 8'h0C;
    localparam logic [7:0] FTM_OFF_COUNT = 8'h10;
    localparam logic [7:0] FTM_OFF_HIGH = 8'h14;
    localparam logic [7:0] FTM_OFF_LOW = 8'h18;

    // Control register fields
    localparam int FTM_CTRL_ENABLE_BIT = 0;
    localparam int FTM_CTRL_MODE_BIT = 1;
    localparam int FTM_CTRL_EDGE_LSB = 2;
    localparam int FTM_CTRL_EDGE_MSB = 3;

    // Status, interrupt enable and interrupt clear share this layout
    localparam int FTM_ST_READY_BIT = 0;
    localparam int FTM_ST_LIMIT_BIT = 1;

    // Reset values
    localparam logic [1:0] FTM_EDGE_SEL_RST = 2'h0;
    localparam logic [1:0] FTM_INT_EN_RST = 2'h0;
    localparam logic [15:0] FTM_HIGH_RST = 16'hFFFF;
    localparam logic [15:0] FTM_LOW_RST = 16'h0000;
    localparam logic [15:0] FTM_COUNT_RST = 16'h0000;
    localparam logic [15:0] FTM_COUNT_MAX = 16'hFFFF;

    // Tach edges per timed window for each edge_count_select code
    localparam logic [3:0] FTM_EDGES_SEL0 = 4'h2;
    localparam logic [3:0] FTM_EDGES_SEL1 = 4'h3;
    localparam logic [3:0] FTM_EDGES_SEL2 = 4'h5;
    localparam logic [3:0] FTM_EDGES_SEL3 = 4'h9;

    // Timed measurement phase
    typedef enum logic [1:0] {
        FTM_IDLE = 2'b01,
        FTM_MEAS = 2'b10
    } ftm_phase_t;

endpackage

/* core/ftm_edge_if.sv */
// Interface: synchronised edge pulses from the pin synchroniser to the monitor core
`timescale 1ns/1ns
`default_nettype none
interface ftm_edge_if;
    logic rise;
    logic fall;
    modport src (output rise, output fall);
    modport dst (input rise, input fall);
endinterface
`default_nettype wire

/* core/ftm_edge_sync.sv */
// Module: two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/1ns
`default_nettype none
module ftm_edge_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    ftm_edge_if.src ev
);
    import ftm_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic rise;
        logic fall;
    } ftm_sync_t;

    ftm_sync_t q;
    ftm_sync_t d;

    // Only s2 reads s1, so a metastable first stage never reaches logic
    always_comb begin
        d = q;
        d.s1 = pin_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.rise = q.s2 & ~q.s3;
        d.fall = ~q.s2 & q.s3;
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ev.rise = q.rise;
    assign ev.fall = q.fall;

    a_sync_single_edge: assert property (
        @(posedge clk_i) disable iff (rst_i)
        q.rise |=> !q.rise && !q.fall)
        else $error("edge pulse lasted more than one cycle");

endmodule
`default_nettype wire

/* core/ftm_top.sv */
// Module: fan tachometer monitor with Wishbone register slave and interrupt
// What this block does
// - Two modes, free-running pulse count or timed edges, picked by measure_mode_select.
// - Mode 0 adds one to pulse_counter on each rising edge of speed_pulse_input.
// - Free-running pulse_counter wraps from its maximum to zero and keeps counting.
// - Mode 1 counts reference timebase cycles over the selected number of tach edges.
// - After the selected edges, latch the count into pulse_counter and set ready.
// - Ready flag set with count_ready_irq_en one raises the block interrupt.
// - Count outside the high/low limit window sets limit_violation_flag.
// - While limit_violation_flag is set with its interrupt enable one the block raises the interrupt.
`timescale 1ns/1ns
`default_nettype none
module ftm_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic speed_pulse_i,
    input wire logic ref_clk_i,
    output logic irq_o
);
    import ftm_pkg::*;

    typedef struct packed {
        logic enable;
        logic mode;
        logic [1:0] edge_sel;
        logic [1:0] int_en;
        logic [1:0] status;
        logic [15:0] pulse_cnt;
        logic [15:0] cycle_cnt;
        logic [3:0] edge_cnt;
        ftm_phase_t phase;
        logic [15:0] high_lim;
        logic [15:0] low_lim;
        logic ack;
        logic [31:0] dat;
        logic irq;
    } ftm_state_t;

    localparam ftm_state_t FTM_STATE_RST = '{
        enable: 1'b0,
        mode: 1'b0,
        edge_sel: FTM_EDGE_SEL_RST,
        int_en: FTM_INT_EN_RST,
        status: 2'h0,
        pulse_cnt: FTM_COUNT_RST,
        cycle_cnt: FTM_COUNT_RST,
        edge_cnt: 4'h0,
        phase: FTM_IDLE,
        high_lim: FTM_HIGH_RST,
        low_lim: FTM_LOW_RST,
        ack: 1'b0,
        dat: 32'h0000_0000,
        irq: 1'b0
    };

    ftm_state_t q;
    ftm_state_t d;

    logic [31:0] wmask;
    logic [31:0] ctrl_rd;
    logic [31:0] ctrl_wr;
    logic [31:0] int_en_wr;
    logic [31:0] high_wr;
    logic [31:0] low_wr;
    logic access;
    logic wr_en;
    logic [1:0] clr_bits;
    logic [1:0] set_bits;
    logic set_ready;
    logic tach_edge;
    logic [15:0] cycle_nx;
    logic [3:0] edge_target;
    logic out_of_window;

    // Synchronised tach and reference timebase edges
    ftm_edge_if tach_ev ();
    ftm_edge_if ref_ev ();

    // Tach pin enters through two flops before any edge logic
    ftm_edge_sync u_tach_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(speed_pulse_i),
        .ev(tach_ev.src)
    );

    // The slow reference clock is sampled, not used as a clock
    ftm_edge_sync u_ref_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ref_clk_i),
        .ev(ref_ev.src)
    );

    // Byte lane mask from the Wishbone select lines
    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign wmask[8*b +: 8] = {8{wb_sel_i[b]}};
    end

    // Current control word and byte-merged write images
    assign ctrl_rd = {28'h000_0000, q.edge_sel, q.mode, q.enable};
    assign ctrl_wr = (ctrl_rd & ~wmask) | (wb_dat_i & wmask);
    assign int_en_wr = ({30'h0000_0000, q.int_en} & ~wmask) | (wb_dat_i & wmask);
    assign high_wr = ({16'h0000, q.high_lim} & ~wmask) | (wb_dat_i & wmask);
    assign low_wr = ({16'h0000, q.low_lim} & ~wmask) | (wb_dat_i & wmask);

    // One answer per request; ack drops the cycle after it is given
    assign access = wb_cyc_i & wb_stb_i & ~q.ack;
    assign wr_en = access & wb_we_i;

    // Window length in tach edges (both edges count in timed mode)
    always_comb begin
        edge_target = FTM_EDGES_SEL0;
        case (q.edge_sel)
            2'h0: edge_target = FTM_EDGES_SEL0;
            2'h1: edge_target = FTM_EDGES_SEL1;
            2'h2: edge_target = FTM_EDGES_SEL2;
            2'h3: edge_target = FTM_EDGES_SEL3;
            default: edge_target = FTM_EDGES_SEL0;
        endcase
    end

    // Window check uses the registered count to keep the comparator off long paths
    assign out_of_window = q.enable &&
        ((q.pulse_cnt > q.high_lim) || (q.pulse_cnt < q.low_lim));

    assign tach_edge = tach_ev.rise | tach_ev.fall;

    // Next state: bus slave, measurement engine and interrupt status
    always_comb begin
        d = q;
        set_ready = 1'b0;
        clr_bits = 2'h0;
        cycle_nx = q.cycle_cnt;
        d.ack = access;

        // Register writes take effect on the edge that raises ack
        if (wr_en) begin
            if ({wb_adr_i[7:2], 2'b00} == FTM_OFF_CTRL) begin
                d.enable = ctrl_wr[FTM_CTRL_ENABLE_BIT];
                d.mode = ctrl_wr[FTM_CTRL_MODE_BIT];
                d.edge_sel = ctrl_wr[FTM_CTRL_EDGE_MSB:FTM_CTRL_EDGE_LSB];
            end else if ({wb_adr_i[7:2], 2'b00} == FTM_OFF_INT_EN) begin
                d.int_en = int_en_wr[1:0];
            end else if ({wb_adr_i[7:2], 2'b00} == FTM_OFF_INT_CLR) begin
                clr_bits = wb_dat_i[1:0] & wmask[1:0];
            end else if ({wb_adr_i[7:2], 2'b00} == FTM_OFF_HIGH) begin
                d.high_lim = high_wr[15:0];
            end else if ({wb_adr_i[7:2], 2'b00} == FTM_OFF_LOW) begin
                d.low_lim = low_wr[15:0];
            end
        end

        // Read data; unmapped and write-only addresses read as zero
        if (access && !wb_we_i) begin
            if ({wb_adr_i[7:2], 2'b00} == FTM_OFF_CTRL) begin
                d.dat = ctrl_rd;
            end else if ({wb_adr_i[7:2], 2'b00} == FTM_OFF_STATUS) begin
                d.dat = {30'h0000_0000, q.status};
            end else if ({wb_adr_i[7:2], 2'b00} == FTM_OFF_INT_EN) begin
                d.dat = {30'h0000_0000, q.int_en};
            end else if ({wb_adr_i[7:2], 2'b00} == FTM_OFF_COUNT) begin
                d.dat = {16'h0000, q.pulse_cnt};
            end else if ({wb_adr_i[7:2], 2'b00} == FTM_OFF_HIGH) begin
                d.dat = {16'h0000, q.high_lim};
            end else if ({wb_adr_i[7:2], 2'b00} == FTM_OFF_LOW) begin
                d.dat = {16'h0000, q.low_lim};
            end else begin
                d.dat = 32'h0000_0000;
            end
        end

        // Reference ticks saturate so a window longer than the counter range latches as the slowest value
        if (ref_ev.rise && (q.cycle_cnt != FTM_COUNT_MAX)) begin
            cycle_nx = 16'(q.cycle_cnt + 16'h0001);
        end

        // Measurement engine; disabling holds the count but drops any open window
        if (!q.enable) begin
            d.phase = FTM_IDLE;
            d.edge_cnt = 4'h0;
            d.cycle_cnt = FTM_COUNT_RST;
        end else if (!q.mode) begin
            d.phase = FTM_IDLE;
            d.edge_cnt = 4'h0;
            d.cycle_cnt = FTM_COUNT_RST;
            if (tach_ev.rise) begin
                d.pulse_cnt = 16'(q.pulse_cnt + 16'h0001);
            end
        end else begin
            case (q.phase)
                FTM_IDLE: begin
                    // The window opens on a tach edge with a cleared cycle count
                    if (tach_edge) begin
                        d.phase = FTM_MEAS;
                        d.edge_cnt = 4'h1;
                        d.cycle_cnt = FTM_COUNT_RST;
                    end
                end
                FTM_MEAS: begin
                    d.cycle_cnt = cycle_nx;
                    if (tach_edge) begin
                        if (4'(q.edge_cnt + 4'h1) == edge_target) begin
                            d.pulse_cnt = cycle_nx;
                            set_ready = 1'b1;
                            d.phase = FTM_IDLE;
                            d.edge_cnt = 4'h0;
                            d.cycle_cnt = FTM_COUNT_RST;
                        end else begin
                            d.edge_cnt = 4'(q.edge_cnt + 4'h1);
                        end
                    end
                end
                default: begin
                    d.phase = FTM_IDLE;
                    d.edge_cnt = 4'h0;
                    d.cycle_cnt = FTM_COUNT_RST;
                end
            endcase
        end

        // Sticky status; a set in the same cycle as its clear wins
        set_bits = 2'h0;
        set_bits[FTM_ST_READY_BIT] = set_ready;
        set_bits[FTM_ST_LIMIT_BIT] = out_of_window;
        d.status = (q.status & ~clr_bits) | set_bits;

        // Level interrupt while any enabled status bit is set
        d.irq = |(d.status & d.int_en);
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= FTM_STATE_RST;
        end else begin
            q <= d;
        end
    end

    // All outputs come straight from the state register
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.dat;
    assign irq_o = q.irq;

    a_mode_zero_count: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (q.enable && !q.mode && tach_ev.rise && q.pulse_cnt != FTM_COUNT_MAX)
        |=> q.pulse_cnt == 16'($past(q.pulse_cnt) + 16'h0001))
        else $error("free-running count did not step on a tach rise");

    a_mode_zero_wrap: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (q.enable && !q.mode && tach_ev.rise && q.pulse_cnt == FTM_COUNT_MAX)
        |=> q.pulse_cnt == 16'h0000)
        else $error("free-running count did not wrap to zero");

    a_mode_one_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (q.enable && q.mode && !set_ready)
        |=> $stable(q.pulse_cnt))
        else $error("timed mode changed the count without a latch");

    a_timed_ref_tick: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (q.enable && q.mode && q.phase == FTM_MEAS && ref_ev.rise && !tach_edge
            && q.cycle_cnt != FTM_COUNT_MAX)
        |=> q.cycle_cnt == 16'($past(q.cycle_cnt) + 16'h0001))
        else $error("reference tick was not counted in the window");

    a_ready_latch: assert property (
        @(posedge clk_i) disable iff (rst_i)
        set_ready |=> q.status[FTM_ST_READY_BIT] && q.pulse_cnt == $past(cycle_nx))
        else $error("timed result not latched with ready flag");

    a_window_restart: assert property (
        @(posedge clk_i) disable iff (rst_i)
        set_ready |=> q.phase == FTM_IDLE && q.cycle_cnt == 16'h0000 && q.edge_cnt == 4'h0)
        else $error("window did not restart after a latch");

    a_ready_irq: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (q.status[FTM_ST_READY_BIT] && q.int_en[FTM_ST_READY_BIT]) |-> irq_o)
        else $error("ready flag with enable did not raise the interrupt");

    a_limit_flag: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (q.enable && (q.pulse_cnt > q.high_lim || q.pulse_cnt < q.low_lim))
        |=> q.status[FTM_ST_LIMIT_BIT] ##1 q.status[FTM_ST_LIMIT_BIT] || out_of_window
            || $past(clr_bits[FTM_ST_LIMIT_BIT]))
        else $error("count outside limits did not set the violation flag");

    a_limit_irq: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (q.status[FTM_ST_LIMIT_BIT] && q.int_en[FTM_ST_LIMIT_BIT]) |-> irq_o)
        else $error("violation flag with enable did not raise the interrupt");

    a_bus_ack_once: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("bus acknowledge lasted more than one cycle");

    a_bus_ack_answer: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("bus request was not answered in one cycle");

    a_idle_count_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !q.enable |=> $stable(q.pulse_cnt))
        else $error("disabled block changed the count");

    a_ready_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (clr_bits[FTM_ST_READY_BIT] && !set_ready) |=> !q.status[FTM_ST_READY_BIT])
        else $error("ready flag survived its clear");

    a_limit_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (clr_bits[FTM_ST_LIMIT_BIT] && !out_of_window) |=> !q.status[FTM_ST_LIMIT_BIT])
        else $error("violation flag survived its clear while in window");

    a_irq_quiet: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(|(q.status & q.int_en)) |-> !irq_o)
        else $error("interrupt raised with no enabled status bit");

    a_ready_irq_rise: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (set_ready && q.int_en[FTM_ST_READY_BIT] && !wr_en) |=> irq_o)
        else $error("ready latch with enable did not raise the interrupt at once");

endmodule
`default_nettype wire

/* dv/ftm_fan_model.sv */
// Model of the fan tach pin and the free-running reference timebase
`timescale 1ns/1ns
`default_nettype none
module ftm_fan_model (
    input wire logic clk_i,
    input wire logic run_i,
    output logic tach_o,
    output logic ref_o
);
    logic [8:0] ph_q = 9'h000;
    logic tach_q = 1'b0;
    logic ref_q = 1'b0;
    // Reference is clk/500; tach flips mid-high, so each tach half holds exactly one ref rise
    // A stopped fan holds its pin level, as a real stalled rotor does
    always_ff @(posedge clk_i) begin
        ph_q <= (ph_q == 9'h1F3) ? 9'h000 : ph_q + 9'h001;
        ref_q <= (ph_q < 9'h0FA);
        if (run_i && ph_q == 9'h07D) begin
            tach_q <= ~tach_q;
        end
    end
    assign tach_o = tach_q;
    assign ref_o = ref_q;
endmodule
`default_nettype wire

/* dv/ftm_top_bench.sv */
// Self-checking bench for the fan tachometer monitor
`timescale 1ns/1ns
`default_nettype none
module ftm_top_bench;
    import ftm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic run = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] sel = 4'hF;
    logic [31:0] dat_o;
    logic ack;
    logic irq;
    logic tach;
    logic refc;
    int bad_count = 0;
    int n_tests = 0;

    always #10 clk_i = ~clk_i;

    // Byte enables come from the bus task; all lanes on unless a test masks some
    ftm_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .speed_pulse_i(tach), .ref_clk_i(refc), .irq_o(irq));
    ftm_fan_model i_fan (.clk_i(clk_i), .run_i(run), .tach_o(tach), .ref_o(refc));

    task automatic test_done;
        $display("Mismatches %0d in %0d checks", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One classic cycle; request held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, input logic [3:0] s = 4'hF);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            chk("bus ack", 32'h0000_0001, {31'h0, ack});
            test_done();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        logic [31:0] q;
        bus(1'b1, a, d, q, s);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(nm, e, q);
    endtask

    // Bounded wait for the interrupt line to reach a level
    task automatic wait_irq(input logic lvl);
        int n;
        for (n = 0; n < 20000 && irq !== lvl; n++) begin
            @(posedge clk_i);
        end
        if (irq !== lvl) begin
            chk("irq", {31'h0, lvl}, {31'h0, irq});
            test_done();
        end
    endtask

    // Let the fan turn k full pulses, then stop it after a falling edge
    task automatic pulses(input int k);
        int n;
        int s;
        logic p;
        s = 0;
        p = tach;
        run <= 1'b1;
        for (n = 0; n < 2000 * k && s < k; n++) begin
            @(posedge clk_i);
            if (p === 1'b1 && tach === 1'b0) begin
                s++;
            end
            p = tach;
        end
        run <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk("pulses", k, s);
    endtask

    initial begin
        logic [31:0] c1;
        logic [31:0] q;
        logic [3:0] ed [4];
        ed = '{FTM_EDGES_SEL0, FTM_EDGES_SEL1, FTM_EDGES_SEL2, FTM_EDGES_SEL3};
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, unmapped place and the write-only clear
        rd("ctrl", FTM_OFF_CTRL, 32'h0000_0000);
        rd("status", FTM_OFF_STATUS, 32'h0000_0000);
        rd("int_en", FTM_OFF_INT_EN, 32'h0000_0000);
        rd("count", FTM_OFF_COUNT, 32'h0000_0000);
        rd("high", FTM_OFF_HIGH, 32'h0000_FFFF);
        // Only byte lane 0 of a masked write lands
        wr(FTM_OFF_HIGH, 32'h0000_1234, 4'h1);
        rd("high masked", FTM_OFF_HIGH, 32'h0000_FF34);
        wr(FTM_OFF_HIGH, 32'h0000_FFFF);
        rd("low", FTM_OFF_LOW, 32'h0000_0000);
        rd("int_clr", FTM_OFF_INT_CLR, 32'h0000_0000);
        rd("unmapped", 8'h1C, 32'h0000_0000);
        // Free-running count, interrupts left off; speed from reading differences
        wr(FTM_OFF_CTRL, 32'h0000_0001);
        pulses(3);
        bus(1'b0, FTM_OFF_COUNT, 32'h0000_0000, c1);
        chk("count mode0", 32'h0000_0003, c1);
        pulses(2);
        bus(1'b0, FTM_OFF_COUNT, 32'h0000_0000, q);
        chk("count delta", 32'h0000_0002, q - c1);
        chk("irq mode0", 32'h0000_0000, {31'h0, irq});
        // A disabled block ignores the fan and keeps its count
        wr(FTM_OFF_CTRL, 32'h0000_0000);
        pulses(1);
        rd("count held", FTM_OFF_COUNT, 32'h0000_0005);
        // Timed mode over every edge selection; one ref rise per tach half
        for (int k = 0; k < 4; k++) begin
            wr(FTM_OFF_CTRL, 32'h0000_0000);
            wr(FTM_OFF_CTRL, 32'h0000_0003 | (k << 2));
            wr(FTM_OFF_INT_EN, 32'h0000_0001);
            wr(FTM_OFF_INT_CLR, 32'h0000_0003);
            run <= 1'b1;
            wait_irq(1'b1);
            rd("count mode1", FTM_OFF_COUNT, ed[k] - 1);
            rd("ready", FTM_OFF_STATUS, 32'h0000_0001);
            wr(FTM_OFF_INT_CLR, 32'h0000_0001);
            wait_irq(1'b0);
            wait_irq(1'b1);
            rd("count again", FTM_OFF_COUNT, ed[k] - 1);
            @(posedge clk_i);
            run <= 1'b0;
        end
        // Limit window on the held count of 8, with masking
        wr(FTM_OFF_INT_EN, 32'h0000_0002);
        wr(FTM_OFF_INT_CLR, 32'h0000_0003);
        wait_irq(1'b0);
        wr(FTM_OFF_HIGH, 32'h0000_0005);
        wait_irq(1'b1);
        wr(FTM_OFF_INT_CLR, 32'h0000_0002);
        rd("limit high", FTM_OFF_STATUS, 32'h0000_0002);
        wr(FTM_OFF_INT_EN, 32'h0000_0000);
        wait_irq(1'b0);
        wr(FTM_OFF_INT_EN, 32'h0000_0002);
        wait_irq(1'b1);
        wr(FTM_OFF_HIGH, 32'h0000_FFFF);
        wr(FTM_OFF_LOW, 32'h0000_0009);
        wr(FTM_OFF_INT_CLR, 32'h0000_0002);
        rd("limit low", FTM_OFF_STATUS, 32'h0000_0002);
        wr(FTM_OFF_LOW, 32'h0000_0000);
        wr(FTM_OFF_INT_CLR, 32'h0000_0002);
        wait_irq(1'b0);
        rd("in window", FTM_OFF_STATUS, 32'h0000_0000);
        test_done();
    end
endmodule
`default_nettype wire
